/* verilog/flash_block_erase_protect.v */
// flash array with block erase, word program and per-region protection
// ----------------------------------------
// What this block does
// - the array holds 128 KB as 128 blocks of 1 KB, each erasable without touching others.
// - a finished erase leaves every bit of the erased block reading as one.
// - protection is set per 2 KB region of two adjacent blocks, each region on its own.
// - a region can be unprotected, read-only or execute-only.
// - erase and program of a read-only region are refused and its contents stay.
// - execute-only regions refuse erase and program and serve only instruction fetch.
// - data reads of execute-only regions are refused, for loads and debugger alike.
// - every processor read answers one clock after it is taken, with no wait states.
// ----------------------------------------
`timescale 1ns/1ps
`include "flash_regs.vh"
module flash_block_erase_protect
(
    // clock and reset
    input wire clk,
    input wire rst_n,
    // instruction fetch read port
    input wire fetch_req,
    input wire [14:0] fetch_addr,
    output wire fetch_valid,
    output wire [31:0] fetch_rdata,
    // data read port, loads and debugger
    input wire data_req,
    input wire data_from_debug,
    input wire [14:0] data_addr,
    output wire data_valid,
    output wire data_err,
    output wire [31:0] data_rdata,
    // program and erase commands
    input wire prog_req,
    input wire [14:0] prog_addr,
    input wire [31:0] prog_wdata,
    input wire erase_req,
    input wire [6:0] erase_block,
    output wire cmd_busy,
    output wire cmd_done,
    output wire cmd_err,
    // protection settings
    input wire [63:0] prot_ro,
    input wire [63:0] prot_xo,
    // violation reporting
    input wire viol_clr,
    output wire viol_flag,
    output wire [1:0] viol_cause,
    output wire viol_debug
);
    // ----------------------------------------
    // state encoding
    // ----------------------------------------
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_ERASE = 2'b10;

    // ----------------------------------------
    // storage and control registers
    // ----------------------------------------
    // non-volatile contents, so no reset on the array
    reg [31:0] mem [0:32767];
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [6:0] er_block_reg;
    reg [6:0] er_block_next;
    reg [7:0] er_word_reg;
    reg [7:0] er_word_next;
    reg fetch_valid_reg;
    reg [31:0] fetch_rdata_reg;
    reg data_valid_reg;
    reg data_err_reg;
    reg [31:0] data_rdata_reg;
    reg done_reg;
    reg done_next;
    reg err_reg;
    reg err_next;
    reg viol_reg;
    reg [1:0] cause_reg;
    reg debug_reg;
    reg mem_we;
    reg [14:0] mem_waddr;
    reg [31:0] mem_wdata;

    wire data_is_xo;
    wire cmd_no_write;
    wire [5:0] cmd_region;
    wire data_refused;
    wire prog_refused;
    wire erase_refused;
    wire viol_set;
    wire [1:0] viol_set_cause;
    wire idle;

    // ----------------------------------------
    // protection lookups
    // ----------------------------------------
    // erase names a block; its region is the block index without its low bit
    assign cmd_region = erase_req ? erase_block[6:1] : prog_addr[14:9];

    flash_region_check data_chk
    (
        .region(data_addr[14:9]),
        .prot_ro(prot_ro),
        .prot_xo(prot_xo),
        .is_ro(),
        .is_xo(data_is_xo),
        .no_write()
    );

    flash_region_check cmd_chk
    (
        .region(cmd_region),
        .prot_ro(prot_ro),
        .prot_xo(prot_xo),
        .is_ro(),
        .is_xo(),
        .no_write(cmd_no_write)
    );

    assign idle = state_reg[0];
    assign data_refused = data_req & data_is_xo;
    // erase takes priority when both commands arrive together
    assign erase_refused = idle & erase_req & cmd_no_write;
    assign prog_refused = idle & ~erase_req & prog_req & cmd_no_write;

    // ----------------------------------------
    // command sequencer
    // ----------------------------------------
    always @*
    begin
        state_next = state_reg;
        er_block_next = er_block_reg;
        er_word_next = er_word_reg;
        done_next = 1'b0;
        err_next = 1'b0;
        mem_we = 1'b0;
        mem_waddr = prog_addr;
        mem_wdata = `FL_ERASED;
        case (state_reg)
            ST_IDLE:
            begin
                if (erase_req)
                begin
                    if (cmd_no_write)
                    begin
                        err_next = 1'b1;
                    end
                    else
                    begin
                        er_block_next = erase_block;
                        er_word_next = 8'h00;
                        state_next = ST_ERASE;
                    end
                end
                else if (prog_req)
                begin
                    if (cmd_no_write)
                    begin
                        err_next = 1'b1;
                    end
                    else
                    begin
                        // programming can only clear bits
                        mem_we = 1'b1;
                        mem_waddr = prog_addr;
                        mem_wdata = mem[prog_addr] & prog_wdata;
                        done_next = 1'b1;
                    end
                end
            end
            ST_ERASE:
            begin
                // one word a cycle; only the selected block is touched
                mem_we = 1'b1;
                mem_waddr = {er_block_reg, er_word_reg};
                mem_wdata = `FL_ERASED;
                er_word_next = er_word_reg + 8'h01;
                if (er_word_reg == `FL_BLOCK_LAST)
                begin
                    done_next = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk)
    begin
        if (mem_we)
        begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            er_block_reg <= 7'h00;
            er_word_reg <= 8'h00;
            done_reg <= 1'b0;
            err_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            er_block_reg <= er_block_next;
            er_word_reg <= er_word_next;
            done_reg <= done_next;
            err_reg <= err_next;
        end
    end

    // ----------------------------------------
    // read ports
    // ----------------------------------------
    // reads run beside an erase; data under erase may be old or all ones
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            fetch_valid_reg <= 1'b0;
            fetch_rdata_reg <= `FL_ZERO;
            data_valid_reg <= 1'b0;
            data_err_reg <= 1'b0;
            data_rdata_reg <= `FL_ZERO;
        end
        else
        begin
            fetch_valid_reg <= fetch_req;
            if (fetch_req)
            begin
                // fetch is served in every region, execute-only included
                fetch_rdata_reg <= mem[fetch_addr];
            end
            data_valid_reg <= data_req;
            data_err_reg <= data_refused;
            if (data_req)
            begin
                data_rdata_reg <= data_refused ? `FL_ZERO : mem[data_addr];
            end
        end
    end

    // ----------------------------------------
    // violation flag
    // ----------------------------------------
    assign viol_set = data_refused | erase_refused | prog_refused;
    assign viol_set_cause = erase_refused ? `FL_CAUSE_ERASE :
                            prog_refused ? `FL_CAUSE_PROG : `FL_CAUSE_READ;

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            viol_reg <= 1'b0;
            cause_reg <= `FL_CAUSE_NONE;
            debug_reg <= 1'b0;
        end
        else if (viol_set)
        begin
            // a new violation wins over a clear in the same cycle
            viol_reg <= 1'b1;
            cause_reg <= viol_set_cause;
            debug_reg <= data_refused & data_from_debug & ~erase_refused & ~prog_refused;
        end
        else if (viol_clr)
        begin
            viol_reg <= 1'b0;
            cause_reg <= `FL_CAUSE_NONE;
            debug_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign fetch_valid = fetch_valid_reg;
    assign fetch_rdata = fetch_rdata_reg;
    assign data_valid = data_valid_reg;
    assign data_err = data_err_reg;
    assign data_rdata = data_rdata_reg;
    assign cmd_busy = ~idle;
    assign cmd_done = done_reg;
    assign cmd_err = err_reg;
    assign viol_flag = viol_reg;
    assign viol_cause = cause_reg;
    assign viol_debug = debug_reg;
endmodule

/* verilog/flash_regs.vh */
// constants for the flash array, erase blocks and protection regions
`ifndef FLASH_REGS_VH
`define FLASH_REGS_VH

// ----------------------------------------
// array geometry
// ----------------------------------------
`define FL_TOTAL_BYTES 131072
`define FL_WORD_BITS 32
`define FL_WADDR_W 15
`define FL_WORDS 32768
`define FL_BLOCK_BYTES 1024
`define FL_BLOCK_WORDS 256
`define FL_BLOCK_W 7
`define FL_BLOCK_LSB 8
`define FL_WORD_IN_BLOCK_W 8
`define FL_BLOCK_LAST 8'hFF

// ----------------------------------------
// protection regions
// ----------------------------------------
`define FL_REGION_BYTES 2048
`define FL_REGIONS 64
`define FL_REGION_W 6
`define FL_REGION_LSB 9

// ----------------------------------------
// values
// ----------------------------------------
`define FL_ERASED 32'hFFFFFFFF
`define FL_ZERO 32'h00000000

// ----------------------------------------
// violation cause codes
// ----------------------------------------
`define FL_CAUSE_NONE 2'h0
`define FL_CAUSE_READ 2'h1
`define FL_CAUSE_PROG 2'h2
`define FL_CAUSE_ERASE 2'h3

`endif

/* verilog/flash_region_check.v */
// protection lookup for one region index
`timescale 1ns/1ps
module flash_region_check
(
    // region selection
    input wire [5:0] region,
    // protection settings, one bit per region
    input wire [63:0] prot_ro,
    input wire [63:0] prot_xo,
    // result
    output wire is_ro,
    output wire is_xo,
    output wire no_write
);
    // ----------------------------------------
    // lookup
    // ----------------------------------------
    assign is_ro = prot_ro[region];
    assign is_xo = prot_xo[region];
    // both levels lock the region against modification
    assign no_write = is_ro | is_xo;
endmodule

/* tb/flash_block_erase_protect_properties.sv */
// port assertions for the flash block
`timescale 1ns/1ps
module flash_block_erase_protect_properties
(
    // clock and reset
    input wire clk,
    input wire rst_n,
    // requests
    input wire fetch_req,
    input wire data_req,
    input wire [14:0] data_addr,
    input wire prog_req,
    input wire [14:0] prog_addr,
    input wire erase_req,
    input wire [6:0] erase_block,
    input wire [63:0] prot_ro,
    input wire [63:0] prot_xo,
    input wire viol_clr,
    // answers
    input wire fetch_valid,
    input wire data_valid,
    input wire data_err,
    input wire [31:0] data_rdata,
    input wire cmd_busy,
    input wire cmd_done,
    input wire cmd_err,
    input wire viol_flag
);
    // either protection level blocks writes
    wire [63:0] lock = prot_ro | prot_xo;
    wire idle_erase = erase_req && !cmd_busy;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_fetch_one_cycle: assert property (fetch_req |=> fetch_valid)
        else $error("fetch answer late");
    a_data_one_cycle: assert property (data_req |=> data_valid)
        else $error("data answer late");
    a_xo_read_refused: assert property (data_req && prot_xo[data_addr[14:9]]
        |=> data_err && data_rdata == 32'h00000000) else $error("xo read served");
    a_plain_read_ok: assert property (data_req && !prot_xo[data_addr[14:9]]
        |=> !data_err) else $error("read wrongly refused");
    a_prog_locked: assert property (prog_req && !erase_req && !cmd_busy
        && lock[prog_addr[14:9]] |=> cmd_err && !cmd_done) else $error("prog not refused");
    a_erase_locked: assert property (idle_erase && lock[erase_block[6:1]]
        |=> cmd_err && !cmd_busy) else $error("erase not refused");
    a_erase_length: assert property (idle_erase && !lock[erase_block[6:1]]
        |=> cmd_busy[*8] ##248 cmd_busy ##1 (!cmd_busy && cmd_done))
        else $error("erase length wrong");
    a_err_sets_flag: assert property (data_err |-> viol_flag)
        else $error("flag not set");
    a_flag_sticky: assert property (viol_flag && !viol_clr |=> viol_flag)
        else $error("flag dropped");
endmodule
bind flash_block_erase_protect flash_block_erase_protect_properties
    flash_block_erase_protect_properties_inst (.clk(clk), .rst_n(rst_n),
    .fetch_req(fetch_req), .data_req(data_req), .data_addr(data_addr),
    .prog_req(prog_req), .prog_addr(prog_addr), .erase_req(erase_req),
    .erase_block(erase_block), .prot_ro(prot_ro), .prot_xo(prot_xo), .viol_clr(viol_clr),
    .fetch_valid(fetch_valid), .data_valid(data_valid), .data_err(data_err),
    .data_rdata(data_rdata), .cmd_busy(cmd_busy), .cmd_done(cmd_done), .cmd_err(cmd_err),
    .viol_flag(viol_flag));

/* tb/fetch_host_model.sv */
// instruction fetch requester standing in for the processor
`timescale 1ns/1ps
module fetch_host_model
(
    input wire clk,
    input wire go,
    input wire [14:0] go_addr,
    output wire fetch_req,
    output wire [14:0] fetch_addr
);
    reg [14:0] last_reg = 15'h0000;
    always @(posedge clk)
        if (go)
            last_reg <= go_addr;
    assign fetch_req = go;
    // released address shows garbage, not a stale copy
    assign fetch_addr = go ? go_addr : ~last_reg;
endmodule

/* tb/flash_block_erase_protect_test.sv */
// self-checking bench for the flash block
`timescale 1ns/1ps
module flash_block_erase_protect_test;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg go = 1'b0;
    reg [14:0] go_addr = 15'h0000;
    reg data_req = 1'b0;
    reg data_from_debug = 1'b0;
    reg [14:0] data_addr = 15'h0000;
    reg prog_req = 1'b0;
    reg [14:0] prog_addr = 15'h0000;
    reg [31:0] prog_wdata = 32'h00000000;
    reg erase_req = 1'b0;
    reg [6:0] erase_block = 7'h00;
    reg [63:0] prot_ro = 64'h0;
    reg [63:0] prot_xo = 64'h0;
    reg viol_clr = 1'b0;
    wire fetch_req, fetch_valid, data_valid, data_err, cmd_busy, cmd_done, cmd_err;
    wire viol_flag, viol_debug;
    wire [14:0] fetch_addr;
    wire [31:0] fetch_rdata, data_rdata;
    wire [1:0] viol_cause;
    integer err_total = 0;
    integer tests_run = 0;
    always #10 clk = ~clk;
    fetch_host_model fetch_host_model_inst (.clk(clk), .go(go), .go_addr(go_addr),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr));
    flash_block_erase_protect flash_block_erase_protect_inst (.clk(clk), .rst_n(rst_n),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
        .fetch_rdata(fetch_rdata), .data_req(data_req), .data_from_debug(data_from_debug),
        .data_addr(data_addr), .data_valid(data_valid), .data_err(data_err),
        .data_rdata(data_rdata), .prog_req(prog_req), .prog_addr(prog_addr),
        .prog_wdata(prog_wdata), .erase_req(erase_req), .erase_block(erase_block),
        .cmd_busy(cmd_busy), .cmd_done(cmd_done), .cmd_err(cmd_err), .prot_ro(prot_ro),
        .prot_xo(prot_xo), .viol_clr(viol_clr), .viol_flag(viol_flag),
        .viol_cause(viol_cause), .viol_debug(viol_debug));
    // ----
    // helpers
    // ----
    task chk(input [63:0] got, input [63:0] exp);
    begin
        tests_run = tests_run + 1;
        if (got !== exp)
            begin
            err_total = err_total + 1;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task rd(input [14:0] a, input dbg);
    begin
        @(negedge clk);
        data_req = 1'b1;
        data_addr = a;
        data_from_debug = dbg;
        @(negedge clk);
        data_req = 1'b0;
    end
    endtask
    // erase uses the block of a, program the word a
    task cmd(input e, input [14:0] a, input [31:0] d);
        integer n;
    begin
        @(negedge clk);
        erase_req = e;
        prog_req = !e;
        prog_addr = a;
        prog_wdata = d;
        erase_block = a[14:8];
        @(negedge clk);
        erase_req = 1'b0;
        prog_req = 1'b0;
        n = 0;
        while (cmd_done !== 1'b1 && cmd_err !== 1'b1 && n < 400)
        begin
            @(negedge clk);
            n = n + 1;
        end
        if (n >= 400)
        begin
            err_total = err_total + 1;
            $display("CHECK FAILED t=%0t command never ended", $time);
        end
    end
    endtask
    task test_done;
    begin
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    // ----
    // scenarios
    // ----
    task t_erase;
    begin
        cmd(1'b1, 15'h0300, 32'h0);
        chk(cmd_done, 1);
        cmd(1'b0, 15'h0310, 32'h12345678);
        cmd(1'b1, 15'h0200, 32'h0);
        rd(15'h0200, 1'b0);
        chk(data_rdata, 32'hFFFFFFFF);
        rd(15'h02FF, 1'b0);
        chk(data_rdata, 32'hFFFFFFFF);
        rd(15'h0310, 1'b0);
        chk(data_rdata, 32'h12345678);
        $display("test erase finished");
    end
    endtask
    task t_read_only;
    begin
        prot_ro = 64'h2;
        cmd(1'b0, 15'h0205, 32'h0);
        chk(cmd_err, 1);
        cmd(1'b1, 15'h0310, 32'h0);
        chk(cmd_err, 1);
        rd(15'h0310, 1'b0);
        chk({data_err, data_rdata}, 33'h012345678);
        cmd(1'b0, 15'h0400, 32'hA5A5A5A5);
        chk(cmd_err, 0);
        prot_ro = 64'h0;
        $display("test read only finished");
    end
    endtask
    task t_exec_only;
    begin
        prot_xo = 64'h2;
        rd(15'h0310, 1'b0);
        chk({data_err, data_rdata, viol_flag, viol_cause}, {1'h1, 32'h0, 1'h1, 2'h1});
        rd(15'h0311, 1'b1);
        chk(viol_debug, 1);
        @(negedge clk);
        go = 1'b1;
        go_addr = 15'h0310;
        @(negedge clk);
        go_addr = 15'h0200;
        chk({fetch_valid, fetch_rdata}, 33'h112345678);
        @(negedge clk);
        go = 1'b0;
        chk({fetch_valid, fetch_rdata}, 33'h1FFFFFFFF);
        cmd(1'b1, 15'h0200, 32'h0);
        chk({cmd_err, viol_cause}, 3'h7);
        @(negedge clk);
        viol_clr = 1'b1;
        data_req = 1'b1;
        data_addr = 15'h0310;
        data_from_debug = 1'b0;
        @(negedge clk);
        data_req = 1'b0;
        chk(viol_flag, 1);
        @(negedge clk);
        viol_clr = 1'b0;
        chk(viol_flag, 0);
        prot_xo = 64'h0;
        $display("test execute only finished");
    end
    endtask
    initial
    begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        t_erase;
        t_read_only;
        t_exec_only;
        test_done;
    end
    // about two erases of 257 cycles plus short accesses
    initial
    begin
        #60000;
        err_total = err_total + 1;
        test_done;
    end
endmodule
